//--- bscan_consts.svh
/*
  Constants for the boundary-scan test port: instruction codes, register
  lengths and boundary cell positions.
  Assumes inclusion by bare name from the test port package and module.
*/
// Summary of operation
// - A boundary-scan test port for board interconnect tests, following the standard.
// - A fixed identification code shifts out while the identification instruction is selected.
// - The instruction register holds four bits.
// - Codes 0000 external test, 0001 identification, 0011 internal test, 1111 bypass.
// - Instruction capture always loads 0001, whatever code was written before.
// - Boundary cells cover all digital I/O and core interface signals.
// - Boundary chain is 62 cells; cell 1 ready output, last four inputs and data pin.
// - Cells 26 to 37 hold the twelve counter bus bits, least significant first.
`ifndef BSCAN_CONSTS_SVH
`define BSCAN_CONSTS_SVH

`define IR_LEN        4
`define IR_EXTEST     4'h0
`define IR_IDCODE     4'h1
`define IR_INTEST     4'h3
`define IR_BYPASS     4'hf
`define IR_CAPTURE    4'h1
`define BSR_LEN       62
`define ID_LEN        32
`define CNT_LEN       12
`define CELL_READY    0
`define CELL_CNT_LO   25
`define CELL_CNT_HI   36
`define CELL_SDA_OUT  1
`define CELL_RESET_IN 58
`define CELL_PROM_IN  59
`define CELL_SCL_IN   60
`define CELL_SDA_IN   61
`define NUM_OUT_CELLS 58
// Test clock idles high, so a reset never invents a rising edge
`define SYNC_IDLE     8'h01

`endif

//--- bscan_pkg.sv
/*
  Types for the boundary-scan test port: controller states and instruction.
  Assumes bscan_consts.svh is reachable by bare name.
*/
`default_nettype none
`include "bscan_consts.svh"
package bscan_pkg;
  typedef enum logic [3:0] {
    TLR  = 4'h0, RTI  = 4'h1, SDRS = 4'h2, CDR  = 4'h3,
    SDR  = 4'h4, E1DR = 4'h5, PDR  = 4'h6, E2DR = 4'h7,
    UDR  = 4'h8, SIRS = 4'h9, CIR  = 4'ha, SIR  = 4'hb,
    E1IR = 4'hc, PIR  = 4'hd, E2IR = 4'he, UIR  = 4'hf
  } tap_state_t;
  typedef logic [`IR_LEN-1:0] instr_t;
endpackage
`default_nettype wire

//--- boundary_scan_test_port.sv
/*
  Boundary-scan test port: TAP controller, instruction, identification,
  bypass and 62-cell boundary chain. Test clock is sampled by mclk.
  Assumes the tester keeps the test clock well below mclk/4.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.svh"
module boundary_scan_test_port #(
  parameter logic [`ID_LEN-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  input  wire logic                  test_reset_n,
  output logic                       tdo,
  output logic                       tdoEn,
  input  wire logic [`NUM_OUT_CELLS-1:0] coreOut,
  input  wire logic                  resetPin_n,
  input  wire logic                  config_prom_data_in,
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic [`NUM_OUT_CELLS-1:0]  pinOut,
  output logic                       intestMode,
  output logic [3:0]                 coreIn
);
  // Two-flop synchronisers on all tester and pin inputs
  logic [7:0] s1_r, s2_r;
  logic       tckD_r;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_r   <= `SYNC_IDLE;
      s2_r   <= `SYNC_IDLE;
      tckD_r <= 1'b1;
    end
    else
    begin
      s1_r   <= {sdaIn, sclIn, config_prom_data_in, resetPin_n, test_reset_n, tdi, tms, tck};
      s2_r   <= s1_r;
      tckD_r <= s2_r[0];
    end
  end
  logic tckS, tmsS, tdiS, trstN;
  logic [3:0] pinIn;
  assign tckS  = s2_r[0];
  assign tmsS  = s2_r[1];
  assign tdiS  = s2_r[2];
  assign trstN = s2_r[3];
  assign pinIn = s2_r[7:4];
  logic rise, fall;
  assign rise = tckS & ~tckD_r;
  assign fall = ~tckS & tckD_r;

  bscan_pkg::tap_state_t st_r, st_nxt;
  bscan_pkg::instr_t irSh_r, irSh_nxt, ir_r, ir_nxt;
  logic [`ID_LEN-1:0]  idSh_r, idSh_nxt;
  logic                byp_r, byp_nxt;
  logic [`BSR_LEN-1:0] bsr_r, bsr_nxt, upd_r, upd_nxt;
  logic tdo_r, tdo_nxt, tdoEn_r, tdoEn_nxt;
  logic [`BSR_LEN-1:0] capVec;
  logic selBsr, selId, extMode, intMode;

  // Unlisted codes fall through to bypass
  assign selBsr  = (ir_r == `IR_EXTEST) || (ir_r == `IR_INTEST);
  assign selId   = (ir_r == `IR_IDCODE);
  assign extMode = (ir_r == `IR_EXTEST);
  assign intMode = (ir_r == `IR_INTEST);

  // Cell order: outputs first, then reset, prom data, scl, sda
  always_comb
  begin
    capVec = '0;
    capVec[`NUM_OUT_CELLS-1:0] = coreOut;
    capVec[`CELL_RESET_IN] = pinIn[0];
    capVec[`CELL_PROM_IN]  = pinIn[1];
    capVec[`CELL_SCL_IN]   = pinIn[2];
    capVec[`CELL_SDA_IN]   = pinIn[3];
    if (intMode)
      capVec[`NUM_OUT_CELLS-1:0] = coreOut;
  end

  always_comb
  begin
    st_nxt = st_r;
    if (rise)
    begin
      unique case (st_r)
        bscan_pkg::TLR:  st_nxt = tmsS ? bscan_pkg::TLR  : bscan_pkg::RTI;
        bscan_pkg::RTI:  st_nxt = tmsS ? bscan_pkg::SDRS : bscan_pkg::RTI;
        bscan_pkg::SDRS: st_nxt = tmsS ? bscan_pkg::SIRS : bscan_pkg::CDR;
        bscan_pkg::CDR:  st_nxt = tmsS ? bscan_pkg::E1DR : bscan_pkg::SDR;
        bscan_pkg::SDR:  st_nxt = tmsS ? bscan_pkg::E1DR : bscan_pkg::SDR;
        bscan_pkg::E1DR: st_nxt = tmsS ? bscan_pkg::UDR  : bscan_pkg::PDR;
        bscan_pkg::PDR:  st_nxt = tmsS ? bscan_pkg::E2DR : bscan_pkg::PDR;
        bscan_pkg::E2DR: st_nxt = tmsS ? bscan_pkg::UDR  : bscan_pkg::SDR;
        bscan_pkg::UDR:  st_nxt = tmsS ? bscan_pkg::SDRS : bscan_pkg::RTI;
        bscan_pkg::SIRS: st_nxt = tmsS ? bscan_pkg::TLR  : bscan_pkg::CIR;
        bscan_pkg::CIR:  st_nxt = tmsS ? bscan_pkg::E1IR : bscan_pkg::SIR;
        bscan_pkg::SIR:  st_nxt = tmsS ? bscan_pkg::E1IR : bscan_pkg::SIR;
        bscan_pkg::E1IR: st_nxt = tmsS ? bscan_pkg::UIR  : bscan_pkg::PIR;
        bscan_pkg::PIR:  st_nxt = tmsS ? bscan_pkg::E2IR : bscan_pkg::PIR;
        bscan_pkg::E2IR: st_nxt = tmsS ? bscan_pkg::UIR  : bscan_pkg::SIR;
        bscan_pkg::UIR:  st_nxt = tmsS ? bscan_pkg::SDRS : bscan_pkg::RTI;
      endcase
    end
    if (!trstN)
      st_nxt = bscan_pkg::TLR;
  end

  always_comb
  begin
    irSh_nxt  = irSh_r;
    ir_nxt    = ir_r;
    idSh_nxt  = idSh_r;
    byp_nxt   = byp_r;
    bsr_nxt   = bsr_r;
    upd_nxt   = upd_r;
    tdo_nxt   = tdo_r;
    tdoEn_nxt = tdoEn_r;
    if (rise)
    begin
      unique case (st_r)
        bscan_pkg::CIR: irSh_nxt = `IR_CAPTURE;
        bscan_pkg::SIR: irSh_nxt = {tdiS, irSh_r[`IR_LEN-1:1]};
        bscan_pkg::CDR:
        begin
          idSh_nxt = ID_CODE;
          byp_nxt  = 1'b0;
          if (selBsr)
            bsr_nxt = capVec;
        end
        bscan_pkg::SDR:
        begin
          if (selId)
            idSh_nxt = {tdiS, idSh_r[`ID_LEN-1:1]};
          else if (selBsr)
            bsr_nxt = {tdiS, bsr_r[`BSR_LEN-1:1]};
          else
            byp_nxt = tdiS;
        end
        default:
        begin
        end
      endcase
    end
    if (fall)
    begin
      // Update on the falling edge, as the standard expects
      if (st_r == bscan_pkg::UIR)
        ir_nxt = irSh_r;
      if (st_r == bscan_pkg::UDR && selBsr)
        upd_nxt = bsr_r;
      if (st_r == bscan_pkg::TLR)
        ir_nxt = `IR_IDCODE;
      tdoEn_nxt = (st_r == bscan_pkg::SDR) || (st_r == bscan_pkg::SIR);
      if (st_r == bscan_pkg::SIR)
        tdo_nxt = irSh_r[0];
      else if (selId)
        tdo_nxt = idSh_r[0];
      else if (selBsr)
        tdo_nxt = bsr_r[0];
      else
        tdo_nxt = byp_r;
    end
    if (!trstN)
    begin
      ir_nxt    = `IR_IDCODE;
      tdoEn_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r    <= bscan_pkg::TLR;
      irSh_r  <= `IR_CAPTURE;
      ir_r    <= `IR_IDCODE;
      idSh_r  <= '0;
      byp_r   <= 1'b0;
      bsr_r   <= '0;
      upd_r   <= '0;
      tdo_r   <= 1'b0;
      tdoEn_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      irSh_r  <= irSh_nxt;
      ir_r    <= ir_nxt;
      idSh_r  <= idSh_nxt;
      byp_r   <= byp_nxt;
      bsr_r   <= bsr_nxt;
      upd_r   <= upd_nxt;
      tdo_r   <= tdo_nxt;
      tdoEn_r <= tdoEn_nxt;
    end
  end

  // Pin drive: external test drives update cells, otherwise core passes through
  logic [`NUM_OUT_CELLS-1:0] pin_r, pin_nxt;
  logic                      intest_r;
  logic [3:0]                coreIn_r, coreIn_nxt;
  always_comb
  begin
    pin_nxt    = extMode ? upd_r[`NUM_OUT_CELLS-1:0] : coreOut;
    coreIn_nxt = intMode ? upd_r[`CELL_SDA_IN:`CELL_RESET_IN] : pinIn;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_r    <= '0;
      intest_r <= 1'b0;
      coreIn_r <= 4'h0;
    end
    else
    begin
      pin_r    <= pin_nxt;
      intest_r <= intMode;
      coreIn_r <= coreIn_nxt;
    end
  end
  assign pinOut     = pin_r;
  assign intestMode = intest_r;
  assign coreIn     = coreIn_r;
  assign tdo        = tdo_r;
  assign tdoEn      = tdoEn_r;

  ir_capture_a: assert property (@(posedge mclk) disable iff (rst)
    (rise && st_r == bscan_pkg::CIR && trstN) |=> irSh_r == `IR_CAPTURE)
    else $error("Instruction capture not 0001");
  id_capture_a: assert property (@(posedge mclk) disable iff (rst)
    (rise && st_r == bscan_pkg::CDR && trstN) |=> idSh_r == ID_CODE)
    else $error("Identification code not loaded");
  trst_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !trstN |=> st_r == bscan_pkg::TLR && ir_r == `IR_IDCODE && !tdoEn_r)
    else $error("Test reset ignored");
  bypass_shift_a: assert property (@(posedge mclk) disable iff (rst)
    (rise && st_r == bscan_pkg::SDR && !selId && !selBsr && trstN) |=> byp_r == $past(tdiS))
    else $error("Bypass did not shift");
  bsr_capture_a: assert property (@(posedge mclk) disable iff (rst)
    (rise && st_r == bscan_pkg::CDR && selBsr && trstN)
    |=> bsr_r[`CELL_CNT_HI:`CELL_CNT_LO] == $past(coreOut[`CELL_CNT_HI:`CELL_CNT_LO]))
    else $error("Counter cells misplaced");
  ir_update_a: assert property (@(posedge mclk) disable iff (rst)
    (fall && st_r == bscan_pkg::UIR && trstN) |=> ir_r == $past(irSh_r))
    else $error("Instruction not updated");
  extest_drive_a: assert property (@(posedge mclk) disable iff (rst)
    extMode |=> pinOut == $past(upd_r[`NUM_OUT_CELLS-1:0]))
    else $error("External test not driving pins");
  ir_shift_a: assert property (@(posedge mclk) disable iff (rst)
    (rise && st_r == bscan_pkg::SIR && trstN) |=> irSh_r[`IR_LEN-1] == $past(tdiS))
    else $error("Instruction shift wrong");
endmodule
`default_nettype wire

//--- jtag_tester.sv
/*
  Tester model for the boundary-scan port: drives tck, tms, tdi and the
  test reset, and samples tdo on the tck rise.
  Assumes mclk is the 40 MHz clock; tck runs at 200 ns, 4 mclk per phase.
*/
`timescale 1ns/1ps
`default_nettype none
module jtag_tester (
  input  wire logic mclk,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      test_reset_n
);
  initial
  begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    test_reset_n = 1'b1;
  end
  // Low phase sets tms/tdi, rising edge samples tdo
  task automatic step(input logic t, input logic d, output logic o);
    @(posedge mclk);
    #1;
    tck = 1'b0;
    tms = t;
    tdi = d;
    repeat (4) @(posedge mclk);
    #1;
    tck = 1'b1;
    o = tdo;
    repeat (3) @(posedge mclk);
  endtask
  // Outside shifts tdi toggles so a stale bit never looks valid
  task automatic go(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(seq[i], ~tdi, o);
  endtask
  task automatic reset_tap();
    go(8'h1f, 6);
  endtask
  task automatic shift_ir(input logic [3:0] code, output logic [3:0] cap);
    go(8'h03, 4);
    for (int i = 0; i < 4; i++) step(i == 3, code[i], cap[i]);
    go(8'h01, 2);
  endtask
  task automatic shift_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    go(8'h01, 3);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    go(8'h01, 2);
  endtask
  task automatic pulse_trst();
    @(posedge mclk);
    #1;
    test_reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    test_reset_n = 1'b1;
    repeat (6) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
/*
  Self-checking bench for the boundary-scan port: instruction table loop,
  then system reset and test reset cases.
  Assumes jtag_tester.sv and bscan_consts.svh are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bscan_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  typedef struct {logic [3:0] code; int len; logic ext; logic itst;} row_t;
  localparam logic [31:0] ID = 32'h5a3c_0f96; // Arbitrary value
  localparam logic [63:0] PAT = 64'h9e37_79b9_7f4a_7c15;
  logic                       mclk, rst, tck, tms, tdi, test_reset_n, tdo, tdoEn;
  logic                       resetPin_n, config_prom_data_in, sclIn, sdaIn, intestMode;
  logic [`NUM_OUT_CELLS-1:0]  coreOut, pinOut;
  logic [3:0]                 coreIn, cap;
  logic [63:0]                dout, capv, expv;
  int                         failures = 0, compares = 0, cycles = 0;
  row_t                       rows [6] = '{'{4'h0, 62, 1, 0}, '{4'h1, 32, 0, 0},
    '{4'h3, 62, 0, 1}, '{4'hf, 1, 0, 0}, '{4'h5, 1, 0, 0}, '{4'h8, 1, 0, 0}};
  boundary_scan_test_port #(.ID_CODE(ID)) boundary_scan_test_port_inst (
    .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n),
    .tdo(tdo), .tdoEn(tdoEn), .coreOut(coreOut), .resetPin_n(resetPin_n),
    .config_prom_data_in(config_prom_data_in), .sclIn(sclIn), .sdaIn(sdaIn),
    .pinOut(pinOut), .intestMode(intestMode), .coreIn(coreIn));
  jtag_tester jtag_tester_inst (
    .mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above the roughly 4700 cycles the run needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic hold_reset(input int n);
    @(posedge mclk);
    #1;
    rst = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    `CHK({tdo, tdoEn, pinOut, coreIn}, 64'h0)
    rst = 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  initial
  begin
    rst = 1'b1;
    coreOut = 58'h2ab_cdef_0123_4567;
    {resetPin_n, config_prom_data_in, sclIn, sdaIn} = 4'b1010;
    capv = {2'b00, sdaIn, sclIn, config_prom_data_in, resetPin_n, coreOut};
    hold_reset(8);
    jtag_tester_inst.reset_tap();
    foreach (rows[i])
    begin
      jtag_tester_inst.shift_ir(rows[i].code, cap);
      `CHK(cap, 4'h1)
      jtag_tester_inst.shift_dr(64, PAT, dout);
      expv = (PAT << rows[i].len) |
        (rows[i].len == 32 ? {32'h0, ID} : rows[i].len == 1 ? 64'h0 : capv);
      `CHK(dout, expv)
      if (rows[i].len == 62) `CHK(dout[36:25], coreOut[36:25])
      repeat (8) @(posedge mclk);
      #1;
      `CHK(intestMode, rows[i].itst)
      `CHK(tdoEn, 1'b0)
      if (rows[i].ext) `CHK(pinOut, PAT[59:2])
      else `CHK(pinOut, coreOut)
      if (rows[i].itst) `CHK(coreIn, PAT[63:60])
      else `CHK(coreIn, {sdaIn, sclIn, config_prom_data_in, resetPin_n})
    end
    // Mid-run system reset drops a bypass instruction back to identification
    jtag_tester_inst.shift_ir(4'hf, cap);
    `CHK(cap, 4'h1)
    hold_reset(4);
    jtag_tester_inst.go(8'h00, 1);
    jtag_tester_inst.shift_dr(32, PAT, dout);
    `CHK(dout[31:0], ID)
    jtag_tester_inst.shift_ir(4'h0, cap);
    jtag_tester_inst.pulse_trst();
    jtag_tester_inst.go(8'h00, 1);
    jtag_tester_inst.shift_dr(33, PAT, dout);
    `CHK(dout[32:0], {PAT[0], ID})
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
